/* design/itc_map.svh */
// Register offsets, field positions, reset values and counts of the transfer and SCL configuration block
`ifndef ITC_MAP_SVH
`define ITC_MAP_SVH

// ==========================================================
// Register byte offsets
`define ITC_ADR_CFG 8'h04
`define ITC_ADR_CTL 8'h10

// ==========================================================
// Transfer and SCL configuration fields
`define ITC_BC_HI 7
`define ITC_BC_LO 5
`define ITC_ACK_BIT 4
`define ITC_ONE_BIT 3
`define ITC_SCK_HI 2
`define ITC_SCK_LO 0
`define ITC_MON_BIT 0

// ==========================================================
// Companion control fields
`define ITC_MST_BIT 7
`define ITC_MODE_HI 3
`define ITC_MODE_LO 2
`define ITC_TRIG_HI 1
`define ITC_TRIG_LO 0

// ==========================================================
// Reset values
`define ITC_BC_RST 3'h0
`define ITC_ACK_RST 1'b0
`define ITC_SCK_RST 3'h0
`define ITC_TRIG_RST 2'h0

// ==========================================================
// Counts and codes
`define ITC_FULL_LEN 4'h8
`define ITC_SCK_RSVD 3'h7
`define ITC_N_OFFSET 4'h5
`define ITC_SCL_BASE 12'h048
`define ITC_TRIG_FIRST 2'h2
`define ITC_TRIG_SECOND 2'h1
`define ITC_SRST_CYCLES 8

`endif

/* design/itc_pkg.sv */
// Types shared by the transfer and SCL configuration block
package itc_pkg;

    // ==========================================================
    // Interface operating modes
    typedef enum logic [1:0]
    {
        ITC_MODE_PORT = 2'b00,
        ITC_MODE_SIO = 2'b01,
        ITC_MODE_I2C = 2'b10,
        ITC_MODE_RSVD = 2'b11
    } itc_mode_type;

    // ==========================================================
    // Master clock engine states
    typedef enum logic [0:0]
    {
        ITC_ST_IDLE = 1'b0,
        ITC_ST_RUN = 1'b1
    } itc_state_type;

    // ==========================================================
    // Transfer format and rate settings
    typedef struct packed
    {
        logic [2:0] bits;
        logic ack;
        logic [2:0] sck;
    } itc_cfg_type;

endpackage

/* design/itc_pin_sync.sv */
// Three-stage synchroniser for a pin, level accepted when the last two stages agree
`timescale 1ns/1ps

module itc_pin_sync
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin and filtered level
    input wire logic pin_i,
    output logic level_o
);

    logic meta_r;
    logic mid_r;
    logic last_r;

    // ==========================================================
    // Chain of three flops, idle bus level is high
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= 1'b1;
            mid_r <= 1'b1;
            last_r <= 1'b1;
        end
        else
        begin
            meta_r <= pin_i;
            mid_r <= meta_r;
            last_r <= mid_r;
        end
    end

    // Level follows only once two stable stages agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            level_o <= 1'b1;
        end
        else if (mid_r == last_r)
        begin
            level_o <= last_r;
        end
    end

endmodule

/* design/itc_scl_div.sv */
// SCL period divider giving a fall and a rise point per period of 2^n + 72 system clocks
`timescale 1ns/1ps
`include "itc_map.svh"

module itc_scl_div
#(
    parameter int CNT_W = 12
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic [2:0] sel_i,
    // Period points
    output logic fall_o,
    output logic rise_o,
    output logic [CNT_W-1:0] period_o
);

    // Largest period needs twelve bits
    if (CNT_W < 12)
    begin : g_bad_width
        $error("itc_scl_div: CNT_W must be at least 12");
    end

    logic [3:0] shift_w;
    logic [CNT_W-1:0] cnt_r;

    // ==========================================================
    // Period from the rate select
    assign shift_w = {1'b0, sel_i} + `ITC_N_OFFSET;
    assign period_o = (CNT_W'(1) << shift_w) + CNT_W'(`ITC_SCL_BASE);
    assign fall_o = run_i && (cnt_r == '0);
    assign rise_o = run_i && (cnt_r == (period_o >> 1));

    // Free count while running, restart from zero on each run
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            cnt_r <= '0;
        end
        else if (cnt_r == period_o - CNT_W'(1))
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

endmodule

/* design/itc_xfer_cfg.sv */
// Transfer format and SCL rate configuration with Wishbone register access
// What this block does
// - Bits field 000 means eight data bits, others one to seven; ack adds one.
// - Master emits an acknowledge clock after data only when the ack setting is one.
// - Slave counts the acknowledge clock only when the ack setting is one.
// - SCL period is 2^n plus 72 system clocks, n from 5 to 11; 111 reserved.
// - Bit 0 writes the low rate bit; reads the soft reset monitor, 0 while busy.
// - In clocked serial mode the low rate bit starts as zero.
// - Rate select starts at 000 after reset whatever bit 0 reads.
// - Mode field: 00 port, 01 clocked serial, 10 I2C, 11 reserved.
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "itc_map.svh"

module itc_xfer_cfg
    import itc_pkg::*;
#(
    parameter int SRST_CYCLES = `ITC_SRST_CYCLES
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Rest of the unit
    input wire logic go_i,
    output logic xfer_done_o,
    output logic soft_reset_o,
    output logic [1:0] mode_o,
    output logic master_o,
    // SCL open-drain pin
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o
);

    if (SRST_CYCLES < 1 || SRST_CYCLES > 255)
    begin : g_bad_srst
        $error("itc_xfer_cfg: SRST_CYCLES must be 1 to 255");
    end

    localparam logic [7:0] ADR_CFG = `ITC_ADR_CFG;
    localparam logic [7:0] ADR_CTL = `ITC_ADR_CTL;
    localparam logic [7:0] SRST_LAST = 8'(SRST_CYCLES - 1);

    itc_cfg_type cfg_r;
    itc_mode_type mode_r;
    itc_state_type state_r;
    logic master_r;
    logic [1:0] trig_r;
    logic busy_r;
    logic [7:0] srst_cnt_r;
    logic sck0_wr_r;
    logic [3:0] sent_r;
    logic [3:0] total_r;
    logic [3:0] seen_r;
    logic scl_prev_r;
    logic scl_lvl_w;
    logic fall_w;
    logic rise_w;
    logic req_w;
    logic wr_w;
    logic wr_cfg_w;
    logic wr_ctl_w;
    logic [3:0] len_w;
    logic [3:0] total_w;
    logic i2c_w;
    logic go_ok_w;
    logic m_done_w;
    logic s_edge_w;
    logic s_done_w;

    // ==========================================================
    // Bus decode, one aligned word per register
    assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_w = req_w && wb_we_i && wb_sel_i[0];
    assign wr_cfg_w = wr_w && (wb_adr_i[7:2] == ADR_CFG[7:2]);
    assign wr_ctl_w = wr_w && (wb_adr_i[7:2] == ADR_CTL[7:2]);

    // Data length and total clock count
    assign len_w = (cfg_r.bits == 3'h0) ? `ITC_FULL_LEN : {1'b0, cfg_r.bits};
    assign total_w = len_w + {3'h0, cfg_r.ack};
    assign i2c_w = (mode_r == ITC_MODE_I2C);
    assign go_ok_w = go_i && i2c_w && master_r && !busy_r && (cfg_r.sck != `ITC_SCK_RSVD);

    // ==========================================================
    // Acknowledge one cycle after the request, read data with it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req_w;
            if (req_w && !wb_we_i)
            begin
                if (wb_adr_i[7:2] == ADR_CFG[7:2])
                begin
                    wb_dat_o <= {24'h00_0000, cfg_r.bits, cfg_r.ack, 1'b1, cfg_r.sck[2:1], !busy_r};
                end
                else if (wb_adr_i[7:2] == ADR_CTL[7:2])
                begin
                    wb_dat_o <= {24'h00_0000, master_r, 3'h0, mode_r, 2'h0};
                end
                else
                begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

    // ==========================================================
    // Configuration register, bit 0 writes the low rate bit only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_r.bits <= `ITC_BC_RST;
            cfg_r.ack <= `ITC_ACK_RST;
            cfg_r.sck <= `ITC_SCK_RST;
            sck0_wr_r <= 1'b0;
        end
        else if (wr_cfg_w)
        begin
            cfg_r.bits <= wb_dat_i[`ITC_BC_HI:`ITC_BC_LO];
            cfg_r.ack <= wb_dat_i[`ITC_ACK_BIT];
            cfg_r.sck <= wb_dat_i[`ITC_SCK_HI:`ITC_SCK_LO];
            sck0_wr_r <= 1'b1;
        end
    end

    // Companion control: master select and mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            master_r <= 1'b0;
            mode_r <= ITC_MODE_PORT;
        end
        else if (wr_ctl_w)
        begin
            master_r <= wb_dat_i[`ITC_MST_BIT];
            mode_r <= itc_mode_type'(wb_dat_i[`ITC_MODE_HI:`ITC_MODE_LO]);
        end
    end

    // ==========================================================
    // Soft reset: a 10 then 01 pair in the trigger field starts it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trig_r <= `ITC_TRIG_RST;
            busy_r <= 1'b0;
            srst_cnt_r <= 8'h00;
        end
        else
        begin
            if (wr_ctl_w)
            begin
                trig_r <= wb_dat_i[`ITC_TRIG_HI:`ITC_TRIG_LO];
            end
            if (busy_r)
            begin
                if (srst_cnt_r == SRST_LAST)
                begin
                    busy_r <= 1'b0;
                end
                srst_cnt_r <= srst_cnt_r + 8'h01;
            end
            else if (wr_ctl_w && trig_r == `ITC_TRIG_FIRST
                     && wb_dat_i[`ITC_TRIG_HI:`ITC_TRIG_LO] == `ITC_TRIG_SECOND)
            begin
                busy_r <= 1'b1;
                srst_cnt_r <= 8'h00;
            end
        end
    end

    // ==========================================================
    // SCL period divider, running only during a master transfer
    itc_scl_div #(
        .CNT_W(12)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(state_r == ITC_ST_RUN),
        .sel_i(cfg_r.sck),
        .fall_o(fall_w),
        .rise_o(rise_w),
        .period_o()
    );

    // Filtered SCL level from the pin
    itc_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(scl_i),
        .level_o(scl_lvl_w)
    );

    // ==========================================================
    // Master engine: one low/high pulse per counted clock
    assign m_done_w = (state_r == ITC_ST_RUN) && rise_w && (sent_r + 4'h1 == total_r);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || busy_r)
        begin
            state_r <= ITC_ST_IDLE;
            sent_r <= 4'h0;
            total_r <= 4'h0;
        end
        else
        begin
            unique case (state_r)
                ITC_ST_IDLE:
                begin
                    if (go_ok_w)
                    begin
                        state_r <= ITC_ST_RUN;
                        sent_r <= 4'h0;
                        total_r <= total_w;
                    end
                end
                ITC_ST_RUN:
                begin
                    if (!i2c_w || !master_r || m_done_w)
                    begin
                        state_r <= ITC_ST_IDLE;
                    end
                    if (rise_w)
                    begin
                        sent_r <= sent_r + 4'h1;
                    end
                end
            endcase
        end
    end

    // Pull SCL low in the first half of each period, release in the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i || busy_r || state_r == ITC_ST_IDLE)
        begin
            scl_oe_n_o <= 1'b1;
        end
        else if (fall_w)
        begin
            scl_oe_n_o <= 1'b0;
        end
        else if (rise_w)
        begin
            scl_oe_n_o <= 1'b1;
        end
    end

    // ==========================================================
    // Slave counter: rising SCL edges until the transfer total
    assign s_edge_w = scl_lvl_w && !scl_prev_r;
    assign s_done_w = i2c_w && !master_r && !busy_r && s_edge_w && (seen_r + 4'h1 == total_w);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_prev_r <= 1'b1;
            seen_r <= 4'h0;
        end
        else
        begin
            scl_prev_r <= scl_lvl_w;
            if (!i2c_w || master_r || busy_r || s_done_w)
            begin
                seen_r <= 4'h0;
            end
            else if (s_edge_w)
            begin
                seen_r <= seen_r + 4'h1;
            end
        end
    end

    // ==========================================================
    // Registered outputs to the rest of the unit
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            xfer_done_o <= 1'b0;
            soft_reset_o <= 1'b0;
            mode_o <= ITC_MODE_PORT;
            master_o <= 1'b0;
            scl_o <= 1'b0;
        end
        else
        begin
            xfer_done_o <= m_done_w || s_done_w;
            soft_reset_o <= busy_r;
            mode_o <= mode_r;
            master_o <= master_r;
            scl_o <= 1'b0; // Open drain, only the enable moves
        end
    end

    // ==========================================================
    // Checking helpers
    logic [3:0] rise_cnt_h;
    logic [11:0] gap_h;
    logic [3:0] edge_cnt_h;

    // Counts of generated and observed clocks, and cycles between falls
    always_ff @(posedge clk_i)
    begin
        if (rst_i || state_r == ITC_ST_IDLE)
        begin
            gap_h <= 12'h000;
        end
        else if (fall_w)
        begin
            gap_h <= 12'h001;
        end
        else if (gap_h != 12'h000)
        begin
            gap_h <= gap_h + 12'h001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || go_ok_w)
        begin
            rise_cnt_h <= 4'h0;
        end
        else if (state_r == ITC_ST_RUN && rise_w)
        begin
            rise_cnt_h <= rise_cnt_h + 4'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || xfer_done_o || master_r || !i2c_w || busy_r)
        begin
            edge_cnt_h <= 4'h0;
        end
        else if (s_edge_w)
        begin
            edge_cnt_h <= edge_cnt_h + 4'h1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_length_latch: assert property (go_ok_w && state_r == ITC_ST_IDLE |=>
        total_r == ((cfg_r.bits == 3'h0 ? 4'h8 : {1'b0, cfg_r.bits}) + {3'h0, cfg_r.ack}))
        else $error("latched clock total does not match the bits field");
    a_master_ack: assert property (xfer_done_o && master_r |->
        rise_cnt_h == ((cfg_r.bits == 3'h0 ? 4'h8 : {1'b0, cfg_r.bits}) + (cfg_r.ack ? 4'h1 : 4'h0)))
        else $error("master pulse count wrong for ack setting");
    a_slave_count: assert property (xfer_done_o && !master_r |->
        edge_cnt_h == ((cfg_r.bits == 3'h0 ? 4'h8 : {1'b0, cfg_r.bits}) + (cfg_r.ack ? 4'h1 : 4'h0)))
        else $error("slave done at wrong edge count");
    a_scl_period: assert property (fall_w && gap_h != 12'h000 |->
        gap_h == (12'h001 << ({1'b0, cfg_r.sck} + 4'h5)) + 12'h048)
        else $error("SCL period differs from 2^n+72");
    a_rsvd_rate: assert property (go_i && state_r == ITC_ST_IDLE && cfg_r.sck == 3'h7 |=>
        state_r == ITC_ST_IDLE)
        else $error("reserved rate started a transfer");
    a_monitor_read: assert property (req_w && !wb_we_i && wb_adr_i[7:2] == ADR_CFG[7:2] |=>
        wb_ack_o && wb_dat_o[0] == !$past(busy_r) && wb_dat_o[3])
        else $error("bit 0 read does not show the soft reset monitor");
    a_sio_sck0: assert property (mode_r == ITC_MODE_SIO && !sck0_wr_r |-> !cfg_r.sck[0])
        else $error("low rate bit not zero in clocked serial mode");
    a_reset_rate: assert property ($past(rst_i) |-> cfg_r.sck == 3'h0 && !busy_r)
        else $error("rate select not 000 after reset");
    a_mode_gate: assert property (state_r == ITC_ST_RUN |-> $past(mode_r) == ITC_MODE_I2C && $past(master_r))
        else $error("clock engine ran outside I2C master mode");
    a_srst_length: assert property ($rose(busy_r) |-> busy_r [*1] ##SRST_CYCLES !busy_r)
        else $error("soft reset length wrong");

endmodule

/* verif/itc_bus_peer.sv */
// Far-side bus model: SCL pull-up plus a second master that clocks the line
`timescale 1ns/1ps

module itc_bus_peer
#(
    parameter int HALF = 40
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wire level seen by every party
    input wire logic oe_n_i,
    output logic scl_o,
    // Pulse request from the bench
    input wire logic start_i,
    input wire logic [3:0] cnt_i,
    output logic busy_o
);
    logic pull_r;
    logic [3:0] left_r;
    int tick_r;

    // ==========================================================
    // Wired-and with pull-up: a released line reads high
    assign scl_o = oe_n_i & ~pull_r;
    assign busy_o = left_r != 4'h0;

    // Each pulse: high half, pulled low half, then released
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pull_r <= 1'b0;
            left_r <= 4'h0;
            tick_r <= 0;
        end
        else if (left_r == 4'h0)
        begin
            left_r <= start_i ? cnt_i : 4'h0;
            tick_r <= 0;
        end
        else if (tick_r == HALF - 1)
        begin
            tick_r <= 0;
            pull_r <= ~pull_r;
            if (pull_r)
            begin
                left_r <= left_r - 4'h1;
            end
        end
        else
        begin
            tick_r <= tick_r + 1;
        end
    end
endmodule

/* verif/itc_xfer_cfg_tb.sv */
// Self-checking bench for the transfer and SCL configuration block
`timescale 1ns/1ps
`include "itc_map.svh"

module itc_xfer_cfg_tb;
    logic clk_i, rst_i, go_i, xfer_done_o, soft_reset_o, master_o;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, scl_w, scl_q, scl_oe_n_o, scl_drv;
    logic [3:0] sel_v;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [1:0] mode_o;
    logic peer_go;
    logic [3:0] peer_cnt;
    logic [31:0] rd_q[$];
    logic [31:0] pl_q[$];
    int mismatches, tests_run, fall_cnt, low_cnt, exp_low, done_cnt;

    // ==========================================================
    // Design and far side
    itc_xfer_cfg dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .go_i(go_i), .xfer_done_o(xfer_done_o),
        .soft_reset_o(soft_reset_o), .mode_o(mode_o), .master_o(master_o), .scl_i(scl_w),
        .scl_o(scl_drv), .scl_oe_n_o(scl_oe_n_o));
    itc_bus_peer peer_u (.clk_i(clk_i), .rst_i(rst_i), .oe_n_i(scl_oe_n_o), .scl_o(scl_w),
        .start_i(peer_go), .cnt_i(peer_cnt), .busy_o());

    // Clock generator, 40 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ==========================================================
    // Comparison, verdict and bus tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error: %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task test_done;
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel_v;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50)
        begin
            mismatches++;
            test_done();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Read with the expected word noted for the watcher
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb_cycle(1'b0, adr, 32'h0);
    endtask

    task automatic wait_done;
        int n, d;
        n = 0;
        d = done_cnt;
        while (done_cnt == d && n < 20000)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20000)
        begin
            mismatches++;
            test_done();
        end
    endtask

    task automatic kick;
        fall_cnt = 0;
        go_i <= 1'b1;
        @(posedge clk_i);
        go_i <= 1'b0;
    endtask

    // Go must leave the line untouched
    task automatic no_clock;
        kick();
        repeat (300) @(posedge clk_i);
        check("line falls", fall_cnt, 32'h0);
    endtask

    task automatic master_xfer(input logic [2:0] bits, input logic ack, input logic [2:0] sel);
        wb_cycle(1'b1, `ITC_ADR_CFG, {24'h0, bits, ack, 1'b0, sel});
        rd(`ITC_ADR_CFG, {24'h0, bits, ack, 1'b1, sel[2:1], 1'b1});
        exp_low = ((1 << (sel + 5)) + 72) / 2;
        pl_q.push_back((bits == 3'h0 ? 8 : bits) + ack);
        kick();
        wait_done();
    endtask

    task automatic slave_xfer(input logic [2:0] bits, input logic ack);
        wb_cycle(1'b1, `ITC_ADR_CFG, {24'h0, bits, ack, 4'h0});
        exp_low = 0;
        pl_q.push_back((bits == 3'h0 ? 8 : bits) + ack);
        peer_cnt <= (bits == 3'h0 ? 4'h8 : {1'b0, bits}) + {3'h0, ack};
        peer_go <= 1'b1;
        @(posedge clk_i);
        peer_go <= 1'b0;
        wait_done();
    endtask

    // ==========================================================
    // Watcher: read data, SCL low time and pulse count per transfer
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && !wb_we_i && rd_q.size() > 0)
            check("read data", wb_dat_o, rd_q.pop_front());
        if (scl_q === 1'b1 && scl_w === 1'b0)
            fall_cnt++;
        scl_q = scl_w;
        if (scl_oe_n_o === 1'b0)
            check("scl drive level", scl_drv, 32'h0);
        if (scl_oe_n_o === 1'b0)
            low_cnt++;
        else if (low_cnt > 0)
        begin
            if (exp_low > 0)
                check("scl low time", low_cnt, exp_low);
            low_cnt = 0;
        end
        if (xfer_done_o === 1'b1)
        begin
            check("pulse count", fall_cnt, pl_q.size() > 0 ? pl_q.pop_front() : 32'hFFFF);
            fall_cnt = 0;
            done_cnt++;
        end
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        {wb_cyc_i, wb_stb_i, wb_we_i, go_i, peer_go} = 5'h00;
        {wb_adr_i, wb_sel_i, wb_dat_i, peer_cnt} = 48'h0;
        sel_v = 4'hF;
        {mismatches, tests_run, fall_cnt, low_cnt, exp_low, done_cnt} = '0;
        scl_q = 1'b1;
        rst_i = 1'b1;
        void'($urandom(21557));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`ITC_ADR_CFG, 32'h09);
        rd(`ITC_ADR_CTL, 32'h0);
        wb_cycle(1'b1, 8'h20, 32'hFF);
        rd(8'h20, 32'h0);
        // Write without the low byte enable must leave the fields alone
        sel_v = 4'hE;
        wb_cycle(1'b1, `ITC_ADR_CFG, 32'hFF);
        sel_v = 4'hF;
        rd(`ITC_ADR_CFG, 32'h09);
        // First transfer on the reset rate
        wb_cycle(1'b1, `ITC_ADR_CTL, 32'h88);
        check("master", master_o, 32'h1);
        exp_low = 52;
        pl_q.push_back(8);
        kick();
        wait_done();
        for (int m = 0; m < 4; m++)
        begin
            wb_cycle(1'b1, `ITC_ADR_CTL, {28'h0, m[1:0], 2'h0});
            check("mode", mode_o, m);
            rd(`ITC_ADR_CTL, {28'h0, m[1:0], 2'h0});
        end
        wb_cycle(1'b1, `ITC_ADR_CFG, 32'h0);
        wb_cycle(1'b1, `ITC_ADR_CTL, 32'h84);
        no_clock();
        wb_cycle(1'b1, `ITC_ADR_CTL, 32'h88);
        for (int i = 0; i < 8; i++)
            master_xfer(i[2:0], 1'($urandom % 2), i == 7 ? 3'h0 : i[2:0]);
        master_xfer(3'h2, 1'b0, 3'h0);
        wb_cycle(1'b1, `ITC_ADR_CFG, 32'h37);
        no_clock();
        wb_cycle(1'b1, `ITC_ADR_CTL, 32'h08);
        slave_xfer(3'h3, 1'b1);
        slave_xfer(3'h2, 1'b0);
        wb_cycle(1'b1, `ITC_ADR_CTL, 32'h0A);
        wb_cycle(1'b1, `ITC_ADR_CTL, 32'h09);
        check("soft reset", soft_reset_o, 32'h1);
        rd(`ITC_ADR_CFG, 32'h48);
        repeat (20) @(posedge clk_i);
        rd(`ITC_ADR_CFG, 32'h49);
        test_done();
    end
endmodule
